//--- include/pbs_pkg.sv
// Shared constants and types for the pipelined burst SRAM interface.
package pbs_pkg;

    // ------------------------------------------------------------------
    // Widths of the address, the word, the lanes and the burst counter.
    // ------------------------------------------------------------------
    localparam int ADDR_W  = 21;
    localparam int DATA_W  = 36;
    localparam int LANES   = 4;
    localparam int LANE_W  = 9;
    localparam int BURST_W = 2;

    // Byte-lane patterns for global write and for no write.
    localparam logic [LANES-1:0] ALL_LANES = 4'hf;
    localparam logic [LANES-1:0] NO_LANES  = 4'h0;

    // ------------------------------------------------------------------
    // Timing counts, in clock cycles.
    // ------------------------------------------------------------------
    localparam int SLEEP_ENTER_CYC = 2;
    localparam int SLEEP_EXIT_CYC  = 2;
    // Cycles after reset release before the strap level is trusted.
    localparam int STRAP_SETTLE_CYC = 3;

    // ------------------------------------------------------------------
    // Bit positions inside the pin synchroniser.
    // ------------------------------------------------------------------
    localparam int SYNC_W     = 3;
    localparam int SYNC_OE    = 0;
    localparam int SYNC_SLEEP = 1;
    localparam int SYNC_STRAP = 2;
    // Output enable idle high, sleep low, strap high (its pulled level).
    localparam logic [SYNC_W-1:0] SYNC_RESET = 3'h5;

    // Sleep sequencer states, Gray coded around the loop.
    typedef enum logic [1:0] {
        PBS_RUN   = 2'b00,
        PBS_ENTER = 2'b01,
        PBS_SLEEP = 2'b11,
        PBS_EXIT  = 2'b10
    } pbs_sleep_t;

    // Synchronous bus controls, all sampled on the rising clock edge.
    typedef struct packed {
        logic             processorAddrStrobeN;
        logic             controllerAddrStrobeN;
        logic             burstAdvanceN;
        logic             globalWriteN;
        logic             byteWriteEnableN;
        logic [LANES-1:0] byteLaneSelectN;
        logic             primaryChipSelectN;
        logic             depthSelectHigh;
        logic             depthSelectLowN;
    } pbs_ctrl_t;

    // Request towards the memory core.
    typedef struct packed {
        logic              wrEn;
        logic [LANES-1:0]  byteEn;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
    } pbs_mem_req_t;

    // State of the interface block, apart from the pin synchroniser.
    typedef struct packed {
        pbs_sleep_t                sleepSt;
        logic [1:0]                sleepCnt;
        logic [1:0]                strapCnt;
        logic                      linear;
        logic                      active;
        logic [ADDR_W-BURST_W-1:0] addrHi;
        logic [BURST_W-1:0]        start;
        logic [BURST_W-1:0]        beat;
        logic                      rdStage;
        logic                      firstRead;
        pbs_mem_req_t              mem;
        logic [DATA_W-1:0]         dqOut;
        logic                      dqOe;
        logic                      sleepActive;
    } pbs_state_t;

endpackage : pbs_pkg

//--- logic/pbs_sync2.sv
// Two-flop synchroniser for pins that are not timed to the clock.
`timescale 1ns/100ps
module pbs_sync2 #(
    parameter int                WIDTH     = 1,
    parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
    // Clock and reset.
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    // Raw and synchronised levels.
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] synced
);

    logic [WIDTH-1:0] firstQ;

    // The first stage feeds only the second stage, nothing else.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            firstQ <= RESET_VAL;
            synced <= RESET_VAL;
        end else begin
            firstQ <= raw;
            synced <= firstQ;
        end
    end

endmodule : pbs_sync2

//--- logic/pbs_burst_map.sv
// Maps burst start bits and beat count to the low address bits.
`timescale 1ns/100ps
module pbs_burst_map (
    // Burst position.
    input  wire logic [1:0] start,
    input  wire logic [1:0] beat,
    // Order select, high for linear.
    input  wire logic       linear,
    // Low address bits of this beat.
    output logic      [1:0] addrLow
);

    // Linear wraps modulo four; interleaved flips bits by the beat count.
    assign addrLow = linear ? 2'(start + beat) : (start ^ beat);

endmodule : pbs_burst_map

//--- logic/pbs_sram_interface.sv
// Synchronous control logic of a pipelined double-deselect burst SRAM.
//
// Overview of operation
// - Register inputs and read data on rising edge.
// - Burst order follows the sampled strap level.
// - Two-bit counter loads start bits, makes four beats.
// - Advance low steps the burst counter.
// - Global write writes all four lanes.
// - Processor strobe ignored while primary select high.
// - Strobe, selected, no write starts read; data next.
// - First cycle after deselect keeps outputs off.
// - Deselect turns outputs off after next edge.
// - Processor-strobe write takes two cycles.
// - First processor-strobe cycle ignores writes and advance.
// - Byte write changes only the selected lanes.
// - Controller-strobe write completes in one cycle.
// - Any write cycle forces data outputs off.
// - Interleaved beats are start XOR beat count.
// - Linear beats count up modulo four.
// - Sleep entry and exit take two cycles.
// - Access pending at sleep entry may drop.
// - Both strobes low means processor strobe wins.
// - Third select sampled only on address load.
// - Strap low is linear, high is interleaved.
`timescale 1ns/100ps
module pbs_sram_interface (
    // Clock and reset.
    input  wire logic                          clk_sys,
    input  wire logic                          rst_b,
    // Synchronous bus address and controls.
    input  wire logic [pbs_pkg::ADDR_W-1:0]    address,
    input  wire pbs_pkg::pbs_ctrl_t            busCtrl,
    // Common data lines, split into in, out and enable.
    input  wire logic [pbs_pkg::DATA_W-1:0]    dqIn,
    output logic      [pbs_pkg::DATA_W-1:0]    dqOut,
    output logic                               dqOe,
    // Asynchronous pins and the burst-order strap.
    input  wire logic                          outputEnableN,
    input  wire logic                          sleepRequest,
    input  wire logic                          burstOrderStrap,
    // Memory core port.
    output pbs_pkg::pbs_mem_req_t              memReq,
    input  wire logic [pbs_pkg::DATA_W-1:0]    memRdData,
    // Status.
    output logic                               sleepActive,
    output logic                               linearOrder
);

    import pbs_pkg::*;

    // ------------------------------------------------------------------
    // State and decode signals.
    // ------------------------------------------------------------------
    pbs_state_t         stateQ;
    pbs_state_t         stateD;
    logic [SYNC_W-1:0]  syncRaw;
    logic [SYNC_W-1:0]  syncOut;
    logic               oeNSync;
    logic               sleepSync;
    logic               strapSync;
    logic               running;
    logic               chipSel;
    logic               procLoad;
    logic               ctrlLoad;
    logic               loadAny;
    logic               deselect;
    logic [LANES-1:0]   laneMask;
    logic               wrAny;
    logic               ctrlWrite;
    logic               startRead;
    logic               carryOn;
    logic               advance;
    logic               contWrite;
    logic               writeNow;
    logic [1:0]         mapStart;
    logic [1:0]         mapBeat;
    logic [1:0]         mapAddr;
    logic               strapDone;

    // ------------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------------

    // Output enable, sleep and strap are not timed to the clock, so
    // they cross two flops; output enable therefore acts two edges late.
    assign syncRaw = {burstOrderStrap, sleepRequest, outputEnableN};

    pbs_sync2 #(
        .WIDTH     (SYNC_W),
        .RESET_VAL (SYNC_RESET)
    ) uSync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .raw     (syncRaw),
        .synced  (syncOut)
    );

    assign oeNSync   = syncOut[SYNC_OE];
    assign sleepSync = syncOut[SYNC_SLEEP];
    assign strapSync = syncOut[SYNC_STRAP];

    // ------------------------------------------------------------------
    // Strobe and select decode.
    // ------------------------------------------------------------------

    // Accesses are only recognised while the sleep sequencer is idle.
    assign running = (stateQ.sleepSt == PBS_RUN);

    // The third select only matters where an address is loaded.
    assign chipSel = ~busCtrl.primaryChipSelectN & busCtrl.depthSelectHigh
                   & ~busCtrl.depthSelectLowN;

    // The processor strobe needs the primary select and beats the other.
    assign procLoad = running & ~busCtrl.processorAddrStrobeN
                    & ~busCtrl.primaryChipSelectN;
    assign ctrlLoad = running & ~busCtrl.controllerAddrStrobeN
                    & ~procLoad;
    assign loadAny  = procLoad | ctrlLoad;
    assign deselect = loadAny & ~chipSel;

    // Global write overrides the byte controls and selects every lane.
    always_comb begin
        if (!busCtrl.globalWriteN) begin
            laneMask = ALL_LANES;
        end else if (!busCtrl.byteWriteEnableN) begin
            laneMask = ~busCtrl.byteLaneSelectN;
        end else begin
            laneMask = NO_LANES;
        end
    end
    assign wrAny = |laneMask;

    // A selected controller-strobe load with write controls writes at once; a
    // selected processor-strobe load always reads, whatever the write pins say.
    assign ctrlWrite = ctrlLoad & chipSel & wrAny;
    assign startRead = loadAny & chipSel & ~ctrlWrite;

    // Cycles with no accepted strobe continue the running burst.
    assign carryOn   = running & stateQ.active & ~loadAny;
    assign advance   = carryOn & ~busCtrl.burstAdvanceN;
    assign contWrite = carryOn & wrAny;
    assign writeNow  = ctrlWrite | contWrite;

    // ------------------------------------------------------------------
    // Burst counter addressing.
    // ------------------------------------------------------------------

    // A load restarts at beat zero from the presented low bits; without
    // advance the counter holds and the same word is accessed again.
    assign mapStart = loadAny ? address[1:0] : stateQ.start;
    always_comb begin
        if (loadAny) begin
            mapBeat = 2'h0;
        end else if (advance) begin
            mapBeat = 2'(stateQ.beat + 2'h1);
        end else begin
            mapBeat = stateQ.beat;
        end
    end

    pbs_burst_map uMap (
        .start   (mapStart),
        .beat    (mapBeat),
        .linear  (stateQ.linear),
        .addrLow (mapAddr)
    );

    // The strap is taken once after its synchroniser has filled.
    assign strapDone = (stateQ.strapCnt == 2'(STRAP_SETTLE_CYC));

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------

    // All state but the pin synchroniser is formed here and registered in one flop group below.
    always_comb begin
        stateD          = stateQ;
        stateD.mem.wrEn = 1'b0;

        // Burst order is fixed from the settled strap level.
        if (!strapDone) begin
            stateD.strapCnt = 2'(stateQ.strapCnt + 2'h1);
            stateD.linear   = ~strapSync;
        end

        // Sleep sequencer: two cycles to go in and two to come out.
        case (stateQ.sleepSt)
            PBS_RUN: begin
                if (sleepSync) begin
                    stateD.sleepSt  = PBS_ENTER;
                    stateD.sleepCnt = 2'h0;
                end
            end
            PBS_ENTER: begin
                if (stateQ.sleepCnt == 2'(SLEEP_ENTER_CYC - 1)) begin
                    stateD.sleepSt     = PBS_SLEEP;
                    stateD.sleepActive = 1'b1;
                end else begin
                    stateD.sleepCnt = 2'(stateQ.sleepCnt + 2'h1);
                end
            end
            PBS_SLEEP: begin
                if (!sleepSync) begin
                    stateD.sleepSt  = PBS_EXIT;
                    stateD.sleepCnt = 2'h0;
                end
            end
            PBS_EXIT: begin
                if (stateQ.sleepCnt == 2'(SLEEP_EXIT_CYC - 1)) begin
                    stateD.sleepSt     = PBS_RUN;
                    stateD.sleepActive = 1'b0;
                end else begin
                    stateD.sleepCnt = 2'(stateQ.sleepCnt + 2'h1);
                end
            end
            default: begin
                stateD.sleepSt     = PBS_RUN;
                stateD.sleepActive = 1'b0;
            end
        endcase

        // Address register and burst counter.
        if (deselect) begin
            stateD.active = 1'b0;
        end else if (loadAny) begin
            stateD.active = 1'b1;
            stateD.addrHi = address[ADDR_W-1:BURST_W];
            stateD.start  = address[1:0];
            stateD.beat   = 2'h0;
        end else if (advance) begin
            stateD.beat = mapBeat;
        end
        if ((loadAny & chipSel) | carryOn) begin
            stateD.mem.addr = {stateD.addrHi, mapAddr};
        end

        // Writes carry the data and lane mask sampled on this edge.
        if (writeNow) begin
            stateD.mem.wrEn   = 1'b1;
            stateD.mem.byteEn = laneMask;
            stateD.mem.wrData = dqIn;
        end

        // A read addressed now is delivered by the output register at
        // the next edge; the core answers from the registered address.
        stateD.rdStage = startRead | (carryOn & ~wrAny);
        // A read that leaves the deselected state is remembered, so its
        // first output cycle is masked at the next edge.
        stateD.firstRead = startRead & ~stateQ.active;
        if (stateQ.rdStage) begin
            stateD.dqOut = memRdData;
        end

        // Drive only data of a pending read, with output enable low, in
        // no write and not in the first cycle out of a deselect. The
        // enable follows the read stage, so a deselect only silences
        // the pins one edge later.
        stateD.dqOe = stateQ.rdStage & ~oeNSync & running
                    & ~writeNow
                    & ~stateQ.firstRead;

        // Leaving the run state ends the burst and any pending read; a write issued in this cycle still goes out.
        if (stateD.sleepSt != PBS_RUN) begin
            stateD.active  = 1'b0;
            stateD.rdStage = 1'b0;
            stateD.dqOe    = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register and outputs.
    // ------------------------------------------------------------------

    // Sleep state lives in plain flops, so stored context survives it.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stateQ <= '0;
        end else begin
            stateQ <= stateD;
        end
    end

    assign dqOut       = stateQ.dqOut;
    assign dqOe        = stateQ.dqOe;
    assign memReq      = stateQ.mem;
    assign sleepActive = stateQ.sleepActive;
    assign linearOrder = stateQ.linear;

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cbSys @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    global_write_a: assert property (
        (ctrlWrite & ~busCtrl.globalWriteN)
            |=> (memReq.wrEn && memReq.byteEn == ALL_LANES))
        else $error("Global write did not enable all lanes.");

    proc_read_a: assert property (
        (procLoad & chipSel) |=> (!memReq.wrEn && stateQ.rdStage))
        else $error("Processor strobe load did not start a read.");

    read_data_a: assert property (
        (startRead & stateQ.active & ~oeNSync & sleepSync == 1'b0)
            |=> ##1 (dqOut == $past(memRdData)))
        else $error("Read data not delivered one edge after address.");

    write_off_a: assert property (
        writeNow |=> !dqOe)
        else $error("Outputs driven during a write cycle.");

    first_mask_a: assert property (
        (startRead & ~stateQ.active) |=> ##1 !dqOe)
        else $error("Outputs driven in first cycle after deselect.");

    deselect_off_a: assert property (
        deselect |=> ##1 !dqOe)
        else $error("Outputs still on two edges after deselect.");

    linear_step_a: assert property (
        (advance & stateQ.linear & strapDone)
            |=> memReq.addr[1:0] == 2'($past(memReq.addr[1:0]) + 2'h1))
        else $error("Linear burst did not count up by one.");

    interleave_map_a: assert property (
        (stateQ.active & ~stateQ.linear & strapDone)
            |-> memReq.addr[1:0] == (stateQ.start ^ stateQ.beat))
        else $error("Interleaved burst address mismatch.");

    hold_addr_a: assert property (
        (carryOn & busCtrl.burstAdvanceN) |=> $stable(memReq.addr))
        else $error("Burst address moved without advance.");

    ignore_strobe_a: assert property (
        (running & stateQ.active & ~sleepSync
            & ~busCtrl.processorAddrStrobeN & busCtrl.primaryChipSelectN
            & busCtrl.controllerAddrStrobeN) |=> stateQ.active)
        else $error("Processor strobe taken with primary select high.");

    sleep_entry_a: assert property (
        (running & sleepSync) |=> !sleepActive [*2] ##1 sleepActive)
        else $error("Sleep entry did not take two cycles.");

endmodule : pbs_sram_interface

//--- verif/pbs_core_model.sv
// Behavioural memory core that sits on the interface's core port.
`timescale 1ns/100ps
module pbs_core_model (
    // Clock.
    input  wire logic                       clk_sys,
    // Request from the interface and read data back.
    input  wire pbs_pkg::pbs_mem_req_t      memReq,
    output logic [pbs_pkg::DATA_W-1:0]      memRdData
);
    import pbs_pkg::*;

    // Only 256 words are kept, so data checks stay inside the low address byte.
    logic [DATA_W-1:0] memArr [256];

    // Unwritten words hold a seeded pattern so stale reads stand out.
    initial begin
        for (int i = 0; i < 256; i++) begin
            memArr[i] = 36'(i) ^ 36'h5a5a5a5a5;
        end
    end

    // Read data follows the request address in the same cycle.
    assign memRdData = memArr[memReq.addr[7:0]];

    // A write pulse stores only the enabled lanes.
    always @(posedge clk_sys) begin
        if (memReq.wrEn === 1'b1) begin
            for (int i = 0; i < LANES; i++) begin
                if (memReq.byteEn[i] === 1'b1) begin
                    memArr[memReq.addr[7:0]][i*LANE_W +: LANE_W] <=
                        memReq.wrData[i*LANE_W +: LANE_W];
                end
            end
        end
    end
endmodule : pbs_core_model

//--- verif/pbs_sram_interface_tb.sv
// Self-checking testbench of the burst SRAM interface block.
`timescale 1ns/100ps
module pbs_sram_interface_tb;
    import pbs_pkg::*;

    // ------------------------------------------------------------------
    // Stimulus, observed outputs and counters.
    // ------------------------------------------------------------------
    logic              clk_sys         = 1'b0;
    logic              rst_b           = 1'b0;
    logic [ADDR_W-1:0] address         = '0;
    pbs_ctrl_t         busCtrl         = '1;
    logic [DATA_W-1:0] dqIn            = '0;
    logic              outputEnableN   = 1'b1;
    logic              sleepRequest    = 1'b0;
    logic              burstOrderStrap = 1'b1;
    logic [DATA_W-1:0] dqOut;
    logic              dqOe;
    pbs_mem_req_t      memReq;
    logic [DATA_W-1:0] memRdData;
    logic              sleepActive;
    logic              linearOrder;
    int                n_fail          = 0;
    int                checks_done     = 0;
    logic [DATA_W-1:0] merged;

    // A 40 ns period clock.
    always #20 clk_sys = ~clk_sys;

    pbs_sram_interface pbs_sram_interface_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .address(address),
        .busCtrl(busCtrl), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
        .outputEnableN(outputEnableN), .sleepRequest(sleepRequest),
        .burstOrderStrap(burstOrderStrap), .memReq(memReq),
        .memRdData(memRdData), .sleepActive(sleepActive),
        .linearOrder(linearOrder));

    pbs_core_model pbs_core_model_inst (
        .clk_sys(clk_sys), .memReq(memReq), .memRdData(memRdData));

    // ------------------------------------------------------------------
    // Shared helpers.
    // ------------------------------------------------------------------
    // Builds a control word; sel high gives all three selects active.
    function automatic pbs_ctrl_t mk(logic ps, logic cs, logic burst_advance_n,
        logic gw, logic byte_write_enable_n, logic [3:0] ln, logic sel);
        pbs_ctrl_t c;
        c = '{ps, cs, burst_advance_n, gw, byte_write_enable_n, ln, ~sel, sel, ~sel};
        return c;
    endfunction : mk

    // Drives one bus cycle; it is sampled at the next rising edge, so a
    // check after a call sees what the previous call asked for.
    task automatic cyc(pbs_ctrl_t c, logic [ADDR_W-1:0] a,
        logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        busCtrl <= c;
        address <= a;
        dqIn    <= d;
        @(negedge clk_sys);
    endtask : cyc

    // Moves output enable at a rising edge; the pin is synchronised, so
    // the block sees the new level two edges later.
    task automatic oe_set(logic lvl);
        @(posedge clk_sys);
        outputEnableN <= lvl;
    endtask : oe_set

    task automatic chk(string nm, logic [DATA_W-1:0] e,
        logic [DATA_W-1:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    // Holds reset for 16 cycles, then waits until the strap is settled.
    task automatic rst(logic strap);
        @(posedge clk_sys);
        rst_b           <= 1'b0;
        burstOrderStrap <= strap;
        outputEnableN   <= 1'b0;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("linearOrder", 36'(!strap), 36'(linearOrder));
    endtask : rst

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    // Four-beat read burst, then a suspended beat that must not move.
    // The suspended beat shows a processor strobe with primary select high.
    task automatic t_burst(logic [1:0] st, logic lin);
        logic [ADDR_W-1:0] a;
        logic [1:0]        lo;
        a = {19'h000a0, st};
        cyc(mk(0, 1, 1, 1, 1, 4'hf, 1), a, '0);
        for (int b = 0; b < 4; b++) begin
            cyc(mk(b != 3, 1, b == 3, 1, 1, 4'hf, b != 3), a, '0);
            lo = lin ? 2'(st + b) : (st ^ 2'(b));
            chk("burst addr", 36'({a[20:2], lo}), 36'(memReq.addr));
        end
        cyc(mk(1, 0, 1, 1, 1, 4'hf, 0), a, '0);
        chk("held addr", 36'({a[20:2], lo}), 36'(memReq.addr));
    endtask : t_burst

    // Controller-strobe write with advance low, which must be ignored.
    task automatic t_wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d,
        logic gw, logic [3:0] ln, logic [3:0] en);
        oe_set(1'b1);
        cyc(mk(1, 0, 0, gw, 0, ln, 1), a, d);
        cyc(mk(1, 0, 1, 1, 1, 4'hf, 0), a, d);
        chk("wrEn", 36'h1, 36'(memReq.wrEn));
        chk("byteEn", 36'(en), 36'(memReq.byteEn));
        chk("wr addr", 36'(a), 36'(memReq.addr));
        chk("wrData", d, memReq.wrData);
        chk("dqOe in write", 36'h0, 36'(dqOe));
        oe_set(1'b0);
    endtask : t_wr

    // Read after a deselect: data one edge later, outputs held off in
    // the first cycle, then deselect turns them off one edge late.
    task automatic t_rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
        cyc(mk(0, 1, 1, 1, 1, 4'hf, 1), a, '0);
        cyc(mk(1, 1, 1, 1, 1, 4'hf, 1), a, '0);
        cyc(mk(1, 1, 1, 1, 1, 4'hf, 1), a, '0);
        chk("dqOut", e, dqOut);
        chk("dqOe first", 36'h0, 36'(dqOe));
        cyc(mk(1, 1, 1, 1, 1, 4'hf, 1), a, '0);
        chk("dqOe later", 36'h1, 36'(dqOe));
        cyc(mk(1, 0, 1, 1, 1, 4'hf, 0), a, '0);
        cyc(mk(1, 0, 1, 1, 1, 4'hf, 0), a, '0);
        chk("dqOe held", 36'h1, 36'(dqOe));
        cyc(mk(1, 0, 1, 1, 1, 4'hf, 0), a, '0);
        chk("dqOe deselect", 36'h0, 36'(dqOe));
    endtask : t_rd

    // Processor-strobe write with both strobes and write low at the load.
    task automatic t_pw(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        oe_set(1'b1);
        cyc(mk(0, 0, 0, 0, 0, 4'h0, 1), a, d);
        cyc(mk(1, 1, 1, 0, 1, 4'hf, 1), a, d);
        chk("wrEn first", 36'h0, 36'(memReq.wrEn));
        cyc(mk(1, 0, 1, 1, 1, 4'hf, 0), a, d);
        chk("wrEn second", 36'h1, 36'(memReq.wrEn));
        chk("pw addr", 36'(a), 36'(memReq.addr));
        chk("pw byteEn", 36'(ALL_LANES), 36'(memReq.byteEn));
        oe_set(1'b0);
    endtask : t_pw

    // Counts negative edges until sleepActive reaches the wanted level.
    task automatic wait_sleep(logic lvl);
        int n;
        n = 0;
        while (sleepActive !== lvl && n < 12) begin
            @(negedge clk_sys);
            n++;
        end
        if (sleepActive !== lvl) begin
            n_fail++;
            $display("[ERR] sleepActive expected %b seen %b", lvl,
                sleepActive);
            tally_and_finish();
        end else begin
            chk("sleep cycles", 36'd6, 36'(n));
        end
    endtask : wait_sleep

    // Sleep entry and exit while deselected, recovery kept idle.
    task automatic t_sleep();
        cyc(mk(1, 1, 1, 1, 1, 4'hf, 0), '0, '0);
        @(posedge clk_sys);
        sleepRequest <= 1'b1;
        wait_sleep(1'b1);
        @(posedge clk_sys);
        sleepRequest <= 1'b0;
        wait_sleep(1'b0);
        repeat (3) cyc(mk(1, 1, 1, 1, 1, 4'hf, 0), '0, '0);
        cyc(mk(1, 0, 1, 1, 1, 4'hf, 0), '0, '0);
    endtask : t_sleep

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        rst(1'b1);
        t_burst(2'b01, 1'b0);
        t_burst(2'b10, 1'b0);
        t_wr(21'h11, 36'h123456789, 1'b0, 4'hf, ALL_LANES);
        t_rd(21'h11, 36'h123456789);
        t_wr(21'h11, 36'hfedcba987, 1'b1, 4'ha, 4'h5);
        merged = 36'h123456789;
        for (int i = 0; i < LANES; i += 2) begin
            merged[i*LANE_W +: LANE_W] =
                LANE_W'(36'hfedcba987 >> (i * LANE_W));
        end
        t_rd(21'h11, merged);
        t_pw(21'h23, 36'h0a5a5a5a5);
        t_rd(21'h23, 36'h0a5a5a5a5);
        t_sleep();
        t_rd(21'h23, 36'h0a5a5a5a5);
        rst(1'b0);
        t_burst(2'b01, 1'b1);
        t_burst(2'b11, 1'b1);
        tally_and_finish();
    end
endmodule : pbs_sram_interface_tb
